// [hdl/dpcc_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DPCC_REGS_SVH
`define DPCC_REGS_SVH

// Register byte offsets on the Wishbone bus
`define DPCC_OFF_CHG_EN      8'h00
`define DPCC_OFF_CTRL        8'h04
`define DPCC_OFF_STATUS      8'h08
`define DPCC_OFF_STRAP       8'h0c

// Control register field positions
`define DPCC_CTRL_FULL_SEQ   0
`define DPCC_CTRL_AUTO_DIS_N 1
`define DPCC_CTRL_VENDOR_EN  2
`define DPCC_CTRL_HICUR_SEL  4

// Reset values: charging off, auto on, highest divider selected
`define DPCC_RST_CHG_EN      4'h0
`define DPCC_RST_CTRL        5'h10

// Status register field positions
`define DPCC_STAT_MODE_LSB   0
`define DPCC_STAT_PWR_LSB    12

// Strap register field positions
`define DPCC_STRAP_CHG_LSB   0
`define DPCC_STRAP_MGMT_N    4
`define DPCC_STRAP_POL       5
`define DPCC_STRAP_EEPROM    6
`define DPCC_STRAP_MODE      7

// Power-enable gap during a mode change
`define DPCC_CLK_MHZ         20
`define DPCC_PWR_GAP_US      100
`define DPCC_PWR_GAP_CYCLES  (`DPCC_PWR_GAP_US * `DPCC_CLK_MHZ)

`endif

// [hdl/dpcc_pkg.sv]
// Types shared by the port charging controller
package dpcc_pkg;

  // Charging mode of one downstream port
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_CDP,
    MODE_DCP,
    MODE_DIV_HIGH,
    MODE_DIV_MID,
    MODE_DIV_LOW,
    MODE_VENDOR,
    MODE_GAP
  } dpcc_mode_t;

endpackage : dpcc_pkg

// [hdl/dpcc_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dpcc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // First stage is only read by the second
  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;

endmodule : dpcc_sync

// [hdl/dpcc_wb_regs.sv]
// Wishbone classic slave holding the charging configuration registers
`timescale 1ns/100ps
`include "dpcc_regs.svh"
module dpcc_wb_regs import dpcc_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Register contents and read-only state
  output logic      [3:0]  chgEn,
  output logic      [4:0]  ctrl,
  input  wire logic [15:0] statusWord,
  input  wire logic [7:0]  strapWord
);

  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [3:0]  chgEn_r;
  logic [3:0]  chgEn_nxt;
  logic [4:0]  ctrl_r;
  logic [4:0]  ctrl_nxt;
  logic        req;
  logic        wrTake;

  // Ack one cycle after the request; write lands when master sees ack
  always_comb begin
    req       = wb_cyc_i & wb_stb_i;
    wrTake    = req & wb_we_i & ack_r & wb_sel_i[0];
    ack_nxt   = req & ~ack_r;
    chgEn_nxt = chgEn_r;
    ctrl_nxt  = ctrl_r;
    rdat_nxt  = 32'h0;
    if (wrTake && wb_adr_i == `DPCC_OFF_CHG_EN) begin
      chgEn_nxt = wb_dat_i[3:0];
    end else if (wrTake && wb_adr_i == `DPCC_OFF_CTRL) begin
      ctrl_nxt = wb_dat_i[4:0];
    end
    // Unmapped offsets read as zero and ignore writes
    if (wb_adr_i == `DPCC_OFF_CHG_EN) begin
      rdat_nxt = {28'h0, chgEn_r};
    end else if (wb_adr_i == `DPCC_OFF_CTRL) begin
      rdat_nxt = {27'h0, ctrl_r};
    end else if (wb_adr_i == `DPCC_OFF_STATUS) begin
      rdat_nxt = {16'h0, statusWord};
    end else if (wb_adr_i == `DPCC_OFF_STRAP) begin
      rdat_nxt = {24'h0, strapWord};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r   <= 1'b0;
      rdat_r  <= 32'h0;
      chgEn_r <= `DPCC_RST_CHG_EN;
      ctrl_r  <= `DPCC_RST_CTRL;
    end else begin
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
      chgEn_r <= chgEn_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign chgEn    = chgEn_r;
  assign ctrl     = ctrl_r;

endmodule : dpcc_wb_regs

// [hdl/dpcc_top.sv]
// Downstream port charging-mode controller for a four-port hub
//
// Behaviour
// - Each port has its own charge enable; clear means no indication.
// - Charging downstream mode only with bus power, configured, port power.
// - Upstream unconnected and enabled gives dedicated charging mode.
// - Divider and vendor modes only when unconnected with auto sequencing.
// - Divider mode drives a fixed level; default is the highest level.
// - High-current select picks highest divider or lower mid level.
// - Unconnected and enabled port drives its power enable active.
// - Auto sequencing disabled keeps the port in dedicated charging mode.
// - Auto on, full sequence clear: start at highest enabled divider.
// - Stay in a divider level while no data-line pull-up is seen.
// - Pull-up in divider: power off, go vendor or dedicated, power on.
// - Pull-up in vendor mode: power off, go dedicated, power on.
// - Pull-up or voltage detect in dedicated: power off, back to divider.
// - Sequence repeats until the upstream port becomes connected.
// - Full sequence steps from the first divider down to the lowest before vendor or dedicated.
// - Serial mode without config memory takes modes from strap pins.
// - Straps for enable, interface select and polarity caught at reset.
// - Auto-sequence control bit is active low; set means plain dedicated.
// - Without full sequence or vendor, alternate one divider and dedicated.
`timescale 1ns/100ps
`include "dpcc_regs.svh"
module dpcc_top import dpcc_pkg::*; #(
  parameter int NPORTS     = 4,
  parameter int GAP_CYCLES = `DPCC_PWR_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Wishbone register access
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Upstream state from the hub core (same clock)
  input  wire logic              upstreamVbusValid,
  input  wire logic              upstreamConfigured,
  input  wire logic [NPORTS-1:0] hostPortPower,
  // Per-port data-line detectors (pins)
  input  wire logic [NPORTS-1:0] dpPullupDetect,
  input  wire logic [NPORTS-1:0] dataLineVoltageDetect,
  // Strap pins
  input  wire logic [NPORTS-1:0] chargeEnableStrap,
  input  wire logic              mgmtInterfaceSelectN,
  input  wire logic              powerEnablePolarityStrap,
  input  wire logic              eepromPresent,
  // Port outputs
  output logic      [NPORTS-1:0] portPowerEnable,
  output logic      [3*NPORTS-1:0] portModeCode
);

  localparam int CW = $clog2(GAP_CYCLES + 1);

  logic [3:0]        regChgEn;
  logic [4:0]        regCtrl;
  logic [15:0]       statusWord;
  logic [7:0]        strapWord;
  logic [NPORTS-1:0] pullSync;
  logic [NPORTS-1:0] vdatSync;
  logic [NPORTS-1:0] strapChgSync;
  logic              strapMgmtNSync;
  logic              strapPolSync;
  logic              strapEepromSync;

  // Register bus slave
  dpcc_wb_regs u_regs (
    .clk        (clk),
    .srst       (srst),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_we_i    (wb_we_i),
    .wb_adr_i   (wb_adr_i),
    .wb_sel_i   (wb_sel_i),
    .wb_dat_i   (wb_dat_i),
    .wb_dat_o   (wb_dat_o),
    .wb_ack_o   (wb_ack_o),
    .chgEn      (regChgEn),
    .ctrl       (regCtrl),
    .statusWord (statusWord),
    .strapWord  (strapWord)
  );

  // Detector pins and straps come from outside the clock domain
  dpcc_sync #(.WIDTH(2*NPORTS)) u_syncDet (
    .clk     (clk),
    .srst    (srst),
    .asyncIn ({dpPullupDetect, dataLineVoltageDetect}),
    .syncOut ({pullSync, vdatSync})
  );

  dpcc_sync #(.WIDTH(NPORTS+3)) u_syncStrap (
    .clk     (clk),
    .srst    (1'b0),
    .asyncIn ({chargeEnableStrap, mgmtInterfaceSelectN,
               powerEnablePolarityStrap, eepromPresent}),
    .syncOut ({strapChgSync, strapMgmtNSync, strapPolSync,
               strapEepromSync})
  );

  // Strap capture; sync chain is not reset so it is live at release
  logic              rstDly_r;
  logic              rstDly_nxt;
  logic [NPORTS-1:0] strapChg_r;
  logic [NPORTS-1:0] strapChg_nxt;
  logic              strapMgmtN_r;
  logic              strapMgmtN_nxt;
  logic              strapPol_r;
  logic              strapPol_nxt;
  logic              strapEeprom_r;
  logic              strapEeprom_nxt;

  always_comb begin
    rstDly_nxt      = srst;
    strapChg_nxt    = strapChg_r;
    strapMgmtN_nxt  = strapMgmtN_r;
    strapPol_nxt    = strapPol_r;
    strapEeprom_nxt = strapEeprom_r;
    if (rstDly_r && !srst) begin
      strapChg_nxt    = strapChgSync;
      strapMgmtN_nxt  = strapMgmtNSync;
      strapPol_nxt    = strapPolSync;
      strapEeprom_nxt = strapEepromSync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rstDly_r      <= 1'b1;
      strapChg_r    <= '0;
      strapMgmtN_r  <= 1'b0;
      strapPol_r    <= 1'b1;
      strapEeprom_r <= 1'b0;
    end else begin
      rstDly_r      <= rstDly_nxt;
      strapChg_r    <= strapChg_nxt;
      strapMgmtN_r  <= strapMgmtN_nxt;
      strapPol_r    <= strapPol_nxt;
      strapEeprom_r <= strapEeprom_nxt;
    end
  end

  // Effective configuration: straps override registers in serial mode without config memory
  logic              strapMode;
  logic [NPORTS-1:0] enEff;
  logic              autoOn;
  logic              fullSeq;
  logic              hiCur;
  logic              vendorEn;
  logic              usConnected;
  dpcc_mode_t        firstDiv;

  always_comb begin
    strapMode   = strapMgmtN_r & ~strapEeprom_r;
    enEff       = strapMode ? strapChg_r : regChgEn[NPORTS-1:0];
    autoOn      = strapMode | ~regCtrl[`DPCC_CTRL_AUTO_DIS_N];
    fullSeq     = strapMode | regCtrl[`DPCC_CTRL_FULL_SEQ];
    hiCur       = strapMode | regCtrl[`DPCC_CTRL_HICUR_SEL];
    vendorEn    = regCtrl[`DPCC_CTRL_VENDOR_EN];
    usConnected = upstreamVbusValid;
    // Highest enabled divider level
    firstDiv    = hiCur ? MODE_DIV_HIGH : MODE_DIV_MID;
  end

  // Per-port mode sequencer
  dpcc_mode_t        mode_r   [NPORTS];
  dpcc_mode_t        mode_nxt [NPORTS];
  dpcc_mode_t        target_r [NPORTS];
  dpcc_mode_t        target_nxt [NPORTS];
  logic [CW-1:0]     gapCnt_r [NPORTS];
  logic [CW-1:0]     gapCnt_nxt [NPORTS];
  logic [NPORTS-1:0] pullDly_r;
  logic [NPORTS-1:0] vdatDly_r;
  logic [NPORTS-1:0] pwrPin_r;
  logic [NPORTS-1:0] pwrPin_nxt;
  logic [NPORTS-1:0] pwrActive;

  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_port
      logic       pullEdge;
      logic       vdatEdge;
      dpcc_mode_t afterDiv;

      // Edges only, so a pull-up that stays high moves one step
      always_comb begin
        pullEdge = pullSync[gi] & ~pullDly_r[gi];
        vdatEdge = vdatSync[gi] & ~vdatDly_r[gi];
        afterDiv = vendorEn ? MODE_VENDOR : MODE_DCP;
        mode_nxt[gi]   = mode_r[gi];
        target_nxt[gi] = target_r[gi];
        gapCnt_nxt[gi] = gapCnt_r[gi];
        if (!enEff[gi]) begin
          mode_nxt[gi] = MODE_OFF;
        end else if (usConnected) begin
          // Leaving the sequence also ends any pending gap
          mode_nxt[gi] = (upstreamConfigured && hostPortPower[gi]) ?
                         MODE_CDP : MODE_OFF;
        end else if (!autoOn) begin
          mode_nxt[gi] = MODE_DCP;
        end else begin
          case (mode_r[gi])
            MODE_DIV_HIGH: begin
              if (pullEdge) begin
                mode_nxt[gi]   = MODE_GAP;
                target_nxt[gi] = fullSeq ? MODE_DIV_MID : afterDiv;
                gapCnt_nxt[gi] = CW'(GAP_CYCLES - 1);
              end
            end
            MODE_DIV_MID: begin
              if (pullEdge) begin
                mode_nxt[gi]   = MODE_GAP;
                target_nxt[gi] = fullSeq ? MODE_DIV_LOW : afterDiv;
                gapCnt_nxt[gi] = CW'(GAP_CYCLES - 1);
              end
            end
            MODE_DIV_LOW: begin
              if (pullEdge) begin
                mode_nxt[gi]   = MODE_GAP;
                target_nxt[gi] = afterDiv;
                gapCnt_nxt[gi] = CW'(GAP_CYCLES - 1);
              end
            end
            MODE_VENDOR: begin
              if (pullEdge) begin
                mode_nxt[gi]   = MODE_GAP;
                target_nxt[gi] = MODE_DCP;
                gapCnt_nxt[gi] = CW'(GAP_CYCLES - 1);
              end
            end
            MODE_DCP: begin
              if (pullEdge || vdatEdge) begin
                mode_nxt[gi]   = MODE_GAP;
                target_nxt[gi] = firstDiv;
                gapCnt_nxt[gi] = CW'(GAP_CYCLES - 1);
              end
            end
            MODE_GAP: begin
              if (gapCnt_r[gi] == '0) begin
                mode_nxt[gi] = target_r[gi];
              end else begin
                gapCnt_nxt[gi] = gapCnt_r[gi] - CW'(1);
              end
            end
            default: begin
              // From off or CDP the sequence opens at a divider
              mode_nxt[gi] = firstDiv;
            end
          endcase
        end
        // Power on for any live mode, off in the gap
        pwrActive[gi]  = (mode_nxt[gi] != MODE_OFF) &&
                         (mode_nxt[gi] != MODE_GAP);
        pwrPin_nxt[gi] = pwrActive[gi] ~^ strapPol_r;
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          mode_r[gi]    <= MODE_OFF;
          target_r[gi]  <= MODE_OFF;
          gapCnt_r[gi]  <= '0;
          pullDly_r[gi] <= 1'b0;
          vdatDly_r[gi] <= 1'b0;
          pwrPin_r[gi]  <= 1'b0;
        end else begin
          mode_r[gi]    <= mode_nxt[gi];
          target_r[gi]  <= target_nxt[gi];
          gapCnt_r[gi]  <= gapCnt_nxt[gi];
          pullDly_r[gi] <= pullSync[gi];
          vdatDly_r[gi] <= vdatSync[gi];
          pwrPin_r[gi]  <= pwrPin_nxt[gi];
        end
      end

      // Mode code and status from registered state
      assign portModeCode[3*gi +: 3] = mode_r[gi];
      assign statusWord[`DPCC_STAT_MODE_LSB + 3*gi +: 3] = mode_r[gi];
      assign statusWord[`DPCC_STAT_PWR_LSB + gi] =
        (mode_r[gi] != MODE_OFF) && (mode_r[gi] != MODE_GAP);
    end
  endgenerate

  // Strap readback for software
  always_comb begin
    strapWord = 8'h00;
    strapWord[`DPCC_STRAP_CHG_LSB +: 4] = strapChg_r;
    strapWord[`DPCC_STRAP_MGMT_N]       = strapMgmtN_r;
    strapWord[`DPCC_STRAP_POL]          = strapPol_r;
    strapWord[`DPCC_STRAP_EEPROM]       = strapEeprom_r;
    strapWord[`DPCC_STRAP_MODE]         = strapMode;
  end

  // Pin level; during reset all enables read low
  assign portPowerEnable = pwrPin_r;

endmodule : dpcc_top

// [tb/dpcc_top_assertions.sv]
// Concurrent checks on the charging controller ports
`timescale 1ns/100ps
module dpcc_top_assertions import dpcc_pkg::*; #(
  parameter int NPORTS     = 4,
  parameter int GAP_CYCLES = 2000
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Bus handshake
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_ack_o,
  // Upstream state and port pins
  input  wire logic                upstreamVbusValid,
  input  wire logic                upstreamConfigured,
  input  wire logic [NPORTS-1:0]   dpPullupDetect,
  input  wire logic                powerEnablePolarityStrap,
  input  wire logic [NPORTS-1:0]   portPowerEnable,
  input  wire logic [3*NPORTS-1:0] portModeCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [2:0]  mode0;
  logic        pwrOn;
  logic [15:0] gapCnt_r;
  logic [15:0] gapCnt_nxt;

  // Port 0 view; the polarity strap is held steady by the bench
  assign mode0 = portModeCode[2:0];
  assign pwrOn = (portPowerEnable[0] == powerEnablePolarityStrap);

  // Cycles spent in the current gap, cleared once it ends
  always_comb begin
    gapCnt_nxt = (srst || mode0 != MODE_GAP) ? 16'h0 : gapCnt_r + 16'h1;
  end
  always_ff @(posedge clk) gapCnt_r <= gapCnt_nxt;

  sequence gapEntry;
    ##[2:5] (mode0 == MODE_GAP);
  endsequence
  sequence upHeld;
    upstreamVbusValid [*3];
  endsequence
  sequence unconfHeld;
    !upstreamConfigured [*3];
  endsequence

  chk_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a one-cycle answer");
  chk_gap_power_off: assert property (
    mode0 == MODE_GAP |-> !pwrOn) else $error("power on during gap");
  chk_gap_length: assert property (
    $fell(mode0 == MODE_GAP) |-> gapCnt_r == GAP_CYCLES)
    else $error("gap length wrong");
  chk_off_no_power: assert property (
    mode0 == MODE_OFF |-> !pwrOn) else $error("power on while off");
  chk_unconn_power: assert property (
    mode0 inside {MODE_DCP, MODE_DIV_HIGH, MODE_DIV_MID, MODE_DIV_LOW,
    MODE_VENDOR} |-> pwrOn) else $error("power off in charging mode");
  chk_div_unconn: assert property (upHeld |-> !(mode0 inside
    {MODE_DIV_HIGH, MODE_DIV_MID, MODE_DIV_LOW, MODE_VENDOR}))
    else $error("custom mode while connected");
  chk_cdp_config: assert property (
    unconfHeld |-> mode0 != MODE_CDP) else $error("cdp while unconfigured");
  chk_pullup_react: assert property (
    $rose(dpPullupDetect[0]) && mode0 == MODE_DIV_HIGH |-> gapEntry)
    else $error("no gap after pull-up");
endmodule : dpcc_top_assertions

// [tb/dpcc_device_model.sv]
// Portable device model driving the port data-line detectors
`timescale 1ns/100ps
module dpcc_device_model #(
  parameter int NPORTS = 4
) (
  // Clock
  input  wire logic              clk,
  // Detector pins seen by the hub
  output logic      [NPORTS-1:0] dpPullupDetect,
  output logic      [NPORTS-1:0] dataLineVoltageDetect
);
  initial begin
    dpPullupDetect = '0;
    dataLineVoltageDetect = '0;
  end

  // Attach for hold cycles then let go; under 1 the synchroniser misses it
  task automatic attach(input int port, input bit vdat, input int hold);
    @(posedge clk);
    if (vdat)
      dataLineVoltageDetect[port] <= 1'b1;
    else
      dpPullupDetect[port] <= 1'b1;
    repeat (hold) @(posedge clk);
    dataLineVoltageDetect[port] <= 1'b0;
    dpPullupDetect[port] <= 1'b0;
  endtask : attach
endmodule : dpcc_device_model

// [tb/tb.sv]
// Self-checking bench for the port charging controller
`timescale 1ns/100ps
`include "dpcc_regs.svh"
module tb import dpcc_pkg::*; ;
  localparam int NPORTS     = 4;
  localparam int GAP_CYCLES = 6;
  logic        clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, hostPortPower, chargeEnableStrap;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        upstreamVbusValid, upstreamConfigured, mgmtInterfaceSelectN;
  logic        powerEnablePolarityStrap, eepromPresent;
  logic [3:0]  dpPullupDetect, dataLineVoltageDetect, portPowerEnable;
  logic [11:0] portModeCode;
  int          failures, compares;

  dpcc_top #(.NPORTS(NPORTS), .GAP_CYCLES(GAP_CYCLES)) u_dut (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .upstreamVbusValid(upstreamVbusValid),
    .upstreamConfigured(upstreamConfigured), .hostPortPower(hostPortPower),
    .dpPullupDetect(dpPullupDetect),
    .dataLineVoltageDetect(dataLineVoltageDetect),
    .chargeEnableStrap(chargeEnableStrap),
    .mgmtInterfaceSelectN(mgmtInterfaceSelectN),
    .powerEnablePolarityStrap(powerEnablePolarityStrap),
    .eepromPresent(eepromPresent), .portPowerEnable(portPowerEnable),
    .portModeCode(portModeCode));
  dpcc_device_model #(.NPORTS(NPORTS)) u_dev (.clk(clk),
    .dpPullupDetect(dpPullupDetect),
    .dataLineVoltageDetect(dataLineVoltageDetect));

  always #25 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // Wait for the answer; only the watchdog ends a hung cycle
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    check("ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask : rdchk

  // Bounded wait for a port mode; power unchecked when pw is x
  task automatic wait_mode(input int p, input logic [2:0] m, input logic pw);
    int n;
    n = 0;
    while (portModeCode[3*p +: 3] !== m && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("mode", {29'h0, m}, {29'h0, portModeCode[3*p +: 3]});
    if (pw !== 1'bx)
      check("power", {31'h0, pw}, {31'h0, portPowerEnable[p]});
  endtask : wait_mode

  // Device event, then the power gap, then the next mode
  task automatic step(input int p, input bit vdat, input logic [2:0] m);
    u_dev.attach(p, vdat, 3);
    wait_mode(p, MODE_GAP, 1'b0);
    wait_mode(p, m, 1'b1);
  endtask : step

  // Control changes only with port 0 idle, so no half-done gap remains
  task automatic reconf(input logic [31:0] c);
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'h0);
    wait_mode(0, MODE_OFF, 1'b0);
    wb_cycle(1'b1, `DPCC_OFF_CTRL, c);
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'h1);
  endtask : reconf

  // Straps settle during the whole reset and stay after release
  task automatic do_reset(input logic [3:0] chg, input logic mgmtN);
    @(posedge clk);
    srst <= 1'b1;
    chargeEnableStrap <= chg;
    mgmtInterfaceSelectN <= mgmtN;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {upstreamVbusValid, upstreamConfigured, hostPortPower} = '0;
    {chargeEnableStrap, mgmtInterfaceSelectN, eepromPresent} = '0;
    powerEnablePolarityStrap = 1'b1;
    do_reset(4'h0, 1'b0);
    wb_cycle(1'b1, `DPCC_OFF_STRAP, 32'hffff_ffff);
    wb_cycle(1'b1, 8'h10, 32'hffff_ffff);
    rdchk("chg_en", `DPCC_OFF_CHG_EN, 32'h0);
    rdchk("ctrl", `DPCC_OFF_CTRL, 32'h10);
    rdchk("strap", `DPCC_OFF_STRAP, 32'h20);
    rdchk("unmapped", 8'h10, 32'h0);
    wait_mode(0, MODE_OFF, 1'b0);
    $display("Test reset done");
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'hf);
    for (int p = 0; p < 4; p++) wait_mode(p, MODE_DIV_HIGH, 1'b1);
    rdchk("status", `DPCC_OFF_STATUS, 32'hf6db);
    repeat (20) @(posedge clk);
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'he);
    wait_mode(0, MODE_OFF, 1'b0);
    wait_mode(1, MODE_DIV_HIGH, 1'b1);
    $display("Test enable done");
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'hf);
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    step(0, 1'b0, MODE_DCP);
    step(0, 1'b1, MODE_DIV_HIGH);
    step(0, 1'b0, MODE_DCP);
    step(0, 1'b0, MODE_DIV_HIGH);
    wait_mode(1, MODE_DIV_HIGH, 1'b1);
    $display("Test sequence done");
    reconf(32'h14);
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    step(0, 1'b0, MODE_VENDOR);
    step(0, 1'b0, MODE_DCP);
    reconf(32'h01);
    wait_mode(0, MODE_DIV_MID, 1'b1);
    step(0, 1'b0, MODE_DIV_LOW);
    step(0, 1'b0, MODE_DCP);
    step(0, 1'b1, MODE_DIV_MID);
    reconf(32'h12);
    wait_mode(0, MODE_DCP, 1'b1);
    u_dev.attach(0, 1'b0, 3);
    repeat (GAP_CYCLES + 8) @(posedge clk);
    wait_mode(0, MODE_DCP, 1'b1);
    $display("Test modes done");
    reconf(32'h10);
    @(posedge clk);
    upstreamVbusValid <= 1'b1;
    upstreamConfigured <= 1'b1;
    wait_mode(0, MODE_OFF, 1'b0);
    @(posedge clk);
    hostPortPower <= 4'hf;
    wait_mode(0, MODE_CDP, 1'b1);
    @(posedge clk);
    upstreamConfigured <= 1'b0;
    wait_mode(0, MODE_OFF, 1'b0);
    @(posedge clk);
    upstreamVbusValid <= 1'b0;
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    $display("Test upstream done");
    do_reset(4'h3, 1'b1);
    rdchk("strap", `DPCC_OFF_STRAP, 32'hb3);
    wait_mode(2, MODE_OFF, 1'b0);
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    step(0, 1'b0, MODE_DIV_MID);
    $display("Test straps done");
    // Config memory present: registers rule again, not the straps
    eepromPresent <= 1'b1;
    do_reset(4'h3, 1'b1);
    rdchk("strap", `DPCC_OFF_STRAP, 32'h73);
    wait_mode(0, MODE_OFF, 1'b0);
    wb_cycle(1'b1, `DPCC_OFF_CHG_EN, 32'h1);
    wait_mode(0, MODE_DIV_HIGH, 1'b1);
    step(0, 1'b0, MODE_DCP);
    $display("Test memory done");
    close_out();
  end
endmodule : tb

bind dpcc_top dpcc_top_assertions #(.NPORTS(NPORTS),
  .GAP_CYCLES(GAP_CYCLES)) u_chk (.clk(clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .upstreamVbusValid(upstreamVbusValid),
  .upstreamConfigured(upstreamConfigured),
  .dpPullupDetect(dpPullupDetect),
  .powerEnablePolarityStrap(powerEnablePolarityStrap),
  .portPowerEnable(portPowerEnable), .portModeCode(portModeCode));
